/* File: shared/mnr_pkg.sv */
// Purpose: Shared constants and carriers for the move/no-op/return decoder
// Assumes: 14-bit instruction words, 8-bit data, 13-bit program counter
// Notes:   Phase codes follow the four-phase instruction cycle
package mnr_pkg;
  localparam int INSTR_W = 14;
  localparam int DATA_W  = 8;
  localparam int PC_W    = 13;
  localparam int FADDR_W = 7;
  // Instruction patterns and masks
  localparam logic [13:0] MOVE_MASK  = 14'h3F80;
  localparam logic [13:0] MOVE_PAT   = 14'h0080;
  localparam logic [13:0] NOP_MASK   = 14'h3F9F;
  localparam logic [13:0] NOP_PAT    = 14'h0000;
  localparam logic [13:0] RETINT_PAT = 14'h0009;
  // Global interrupt enable bit position in the interrupt control register
  localparam int GIE_BIT = 7;
  // Cycles taken by the return-from-interrupt instruction
  localparam int RETINT_CYCLES = 2;

  typedef enum logic [1:0] {
    Q1 = 2'b00,
    Q2 = 2'b01,
    Q3 = 2'b10,
    Q4 = 2'b11
  } mnr_phase_e;

  typedef enum logic [1:0] {
    EX_IDLE   = 2'b00,
    EX_MOVE   = 2'b01,
    EX_RETINT = 2'b10,
    EX_FLUSH  = 2'b11
  } mnr_exec_e;

  // Requests toward the datapath
  typedef struct packed {
    logic               fileRead;
    logic               fileWrite;
    logic [FADDR_W-1:0] fileAddr;
    logic [DATA_W-1:0]  fileWData;
    logic               gieSet;
    logic               stackPop;
    logic               pcLoad;
    logic [PC_W-1:0]    pcValue;
    logic               flush;
  } mnr_ctrl_s;
endpackage

/* File: rtl/mnr_phase_gen.sv */
// Purpose: Four-phase counter that splits each instruction cycle
// Assumes: One phase per enabled clock
// Notes:   Signals the last phase; the decoder uses it only in its cycle-wrap assertion
module mnr_phase_gen
(
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic               clkEn,
  // Phase outputs
  output mnr_pkg::mnr_phase_e     phase,
  output logic                    lastPhase
);
  typedef struct packed {
    mnr_pkg::mnr_phase_e ph;
  } mnr_pg_state_s;

  mnr_pg_state_s st_r;
  mnr_pg_state_s st_nxt;

  // Wrap Q4 back to Q1
  always_comb
  begin
    st_nxt = st_r;
    case (st_r.ph)
      mnr_pkg::Q1: st_nxt.ph = mnr_pkg::Q2;
      mnr_pkg::Q2: st_nxt.ph = mnr_pkg::Q3;
      mnr_pkg::Q3: st_nxt.ph = mnr_pkg::Q4;
      default:     st_nxt.ph = mnr_pkg::Q1;
    endcase
  end

  // Frozen while the enable is low
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      st_r <= '{ph: mnr_pkg::Q1};
    else if (clkEn)
      st_r <= st_nxt;
  end

  assign phase     = st_r.ph;
  assign lastPhase = (st_r.ph == mnr_pkg::Q4);
endmodule

/* File: rtl/mnr_decode.sv */
// Purpose: Decode and execute move-to-file, no-op and return-from-interrupt
// Assumes: Instruction word stable from Q1 to Q4 of its cycle
// Notes:   Other opcodes are ignored; status flags are never touched
// Summary of operation
// - Pattern 00 0000 1fff ffff copies working register into file f.
// - Pattern 00 0000 0xx0 0000 is a one-cycle no-op changing nothing.
// - Only the exact word 00 0000 0000 1001 is return-from-interrupt.
// - Return-from-interrupt pops the stack and loads its top into the PC.
// - Return-from-interrupt sets global enable, bit 7 of interrupt control.
// - Return-from-interrupt takes two cycles, the second doing nothing.
// - In its first cycle the enable is set in Q3 and the pop done in Q4.
module mnr_decode
(
  // Clock, reset and freeze
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  input  wire logic                          clkEn,
  // Fetch side
  input  wire logic [mnr_pkg::INSTR_W-1:0]   instrWord,
  // Datapath sources
  input  wire logic [mnr_pkg::DATA_W-1:0]    workingReg,
  input  wire logic [mnr_pkg::PC_W-1:0]      stackTopValue,
  input  wire logic [mnr_pkg::DATA_W-1:0]    intCtrlIn,
  // Control toward datapath, stack and interrupt logic
  output mnr_pkg::mnr_ctrl_s                 ctrlOut,
  output logic [mnr_pkg::DATA_W-1:0]         intCtrlOut,
  output mnr_pkg::mnr_phase_e                phaseOut,
  output mnr_pkg::mnr_exec_e                 execOut,
  output logic                               statusWrite
);
  typedef struct packed {
    mnr_pkg::mnr_exec_e  ex;
    mnr_pkg::mnr_ctrl_s  ctrl;
    logic [mnr_pkg::DATA_W-1:0] intCtrl;
    mnr_pkg::mnr_phase_e ph;
    logic                statusWr;
  } mnr_dec_state_s;

  mnr_dec_state_s      st_r;
  mnr_dec_state_s      st_nxt;
  mnr_pkg::mnr_phase_e phase;
  logic                lastPhase;
  logic                isMove;
  logic                isNop;
  logic                isRetint;

  mnr_phase_gen u_phase
  (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .clkEn     (clkEn),
    .phase     (phase),
    .lastPhase (lastPhase)
  );

  // Opcode matching
  assign isMove   = (instrWord & mnr_pkg::MOVE_MASK) == mnr_pkg::MOVE_PAT;
  assign isNop    = (instrWord & mnr_pkg::NOP_MASK) == mnr_pkg::NOP_PAT;
  assign isRetint = (instrWord == mnr_pkg::RETINT_PAT);

  // Next state: outputs are strobes aligned to the phase after this one
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ph = phase;
    st_nxt.ctrl.fileRead  = 1'b0;
    st_nxt.ctrl.fileWrite = 1'b0;
    st_nxt.ctrl.gieSet    = 1'b0;
    st_nxt.ctrl.stackPop  = 1'b0;
    st_nxt.ctrl.pcLoad    = 1'b0;
    st_nxt.ctrl.flush     = 1'b0;
    st_nxt.intCtrl        = intCtrlIn;
    st_nxt.statusWr       = 1'b0;  // Kept as a flop so the port is registered
    case (st_r.ex)
      mnr_pkg::EX_MOVE:
      begin
        if (phase == mnr_pkg::Q2)
          st_nxt.ctrl.fileRead = 1'b1;
        if (phase == mnr_pkg::Q4)
        begin
          st_nxt.ctrl.fileWrite = 1'b1;
          st_nxt.ctrl.fileWData = workingReg;
        end
      end
      mnr_pkg::EX_RETINT:
      begin
        if (phase == mnr_pkg::Q3)
        begin
          st_nxt.ctrl.gieSet = 1'b1;
          st_nxt.intCtrl[mnr_pkg::GIE_BIT] = 1'b1;
        end
        if (phase == mnr_pkg::Q4)
        begin
          st_nxt.ctrl.stackPop = 1'b1;
          st_nxt.ctrl.pcLoad   = 1'b1;
          st_nxt.ctrl.pcValue  = stackTopValue;
        end
      end
      mnr_pkg::EX_FLUSH:
        ;                                                // Word is dropped
      default:
        ;
    endcase
    // Decode happens in Q1 of each cycle; the flush cycle ignores the fetch
    if (phase == mnr_pkg::Q1)
    begin
      if (st_r.ex == mnr_pkg::EX_RETINT)
        st_nxt.ex = mnr_pkg::EX_FLUSH;
      else if (isMove)
      begin
        st_nxt.ex = mnr_pkg::EX_MOVE;
        st_nxt.ctrl.fileAddr = instrWord[mnr_pkg::FADDR_W-1:0];
      end
      else if (isRetint)
        st_nxt.ex = mnr_pkg::EX_RETINT;
      else
        st_nxt.ex = mnr_pkg::EX_IDLE;
    end
    // Flush spans Q1 to Q4 of the second cycle, never the next decode
    st_nxt.ctrl.flush = (st_nxt.ex == mnr_pkg::EX_FLUSH);
  end

  // Registered state; a low enable freezes everything
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      st_r <= '0;
    else if (clkEn)
      st_r <= st_nxt;
  end

  // Decoded class applies during the phase after Q1 is seen
  assign ctrlOut     = st_r.ctrl;
  assign intCtrlOut  = st_r.intCtrl;
  assign phaseOut    = st_r.ph;
  assign execOut     = st_r.ex;
  assign statusWrite = st_r.statusWr;  // None of these instructions alter flags

  // Assertions
  property p_move_write;
    @(posedge sys_clk) disable iff (!rst_n)
    (clkEn && st_r.ex == mnr_pkg::EX_MOVE && phase == mnr_pkg::Q4)
      |=> (ctrlOut.fileWrite && ctrlOut.fileWData == $past(workingReg));
  endproperty
  a_move_write: assert property (p_move_write)
    else $error("move did not write working register");

  property p_nop_quiet;
    @(posedge sys_clk) disable iff (!rst_n)
    (execOut == mnr_pkg::EX_IDLE) |-> !(ctrlOut.fileWrite || ctrlOut.stackPop
      || ctrlOut.gieSet || ctrlOut.pcLoad);
  endproperty
  a_nop_quiet: assert property (p_nop_quiet)
    else $error("idle cycle produced an action");

  property p_no_status;
    @(posedge sys_clk) disable iff (!rst_n) !statusWrite;
  endproperty
  a_no_status: assert property (p_no_status)
    else $error("status flags written");

  property p_pop_loads_pc;
    @(posedge sys_clk) disable iff (!rst_n)
    ctrlOut.stackPop |-> (ctrlOut.pcLoad && execOut == mnr_pkg::EX_RETINT);
  endproperty
  a_pop_loads_pc: assert property (p_pop_loads_pc)
    else $error("pop without program counter load");

  property p_gie_set;
    @(posedge sys_clk) disable iff (!rst_n)
    ctrlOut.gieSet |-> intCtrlOut[mnr_pkg::GIE_BIT];
  endproperty
  a_gie_set: assert property (p_gie_set)
    else $error("global enable not set");

  property p_flush_follows;
    @(posedge sys_clk) disable iff (!rst_n)
    (clkEn && execOut == mnr_pkg::EX_RETINT && phase == mnr_pkg::Q1)
      |=> execOut == mnr_pkg::EX_FLUSH;
  endproperty
  a_flush_follows: assert property (p_flush_follows)
    else $error("second cycle not flushed");

  property p_phase_order;
    @(posedge sys_clk) disable iff (!rst_n)
    ctrlOut.gieSet |-> (phaseOut == mnr_pkg::Q3);
  endproperty
  a_phase_order: assert property (p_phase_order)
    else $error("global enable set outside Q3");

  property p_read_q2;
    @(posedge sys_clk) disable iff (!rst_n)
    ctrlOut.fileRead |-> (phaseOut == mnr_pkg::Q2 && !ctrlOut.fileWrite);
  endproperty
  a_read_q2: assert property (p_read_q2)
    else $error("file read outside Q2");

  property p_nop_idle;
    @(posedge sys_clk) disable iff (!rst_n)
    (clkEn && phase == mnr_pkg::Q1 && isNop
      && st_r.ex != mnr_pkg::EX_RETINT) |=> execOut == mnr_pkg::EX_IDLE;
  endproperty
  a_nop_idle: assert property (p_nop_idle)
    else $error("no-op not decoded as idle");

  property p_flush_quiet;
    @(posedge sys_clk) disable iff (!rst_n)
    ctrlOut.flush |-> (execOut == mnr_pkg::EX_FLUSH && !(ctrlOut.fileRead
      || ctrlOut.fileWrite || ctrlOut.gieSet || ctrlOut.pcLoad));
  endproperty
  a_flush_quiet: assert property (p_flush_quiet)
    else $error("flush cycle not empty");

  property p_pop_q4;
    @(posedge sys_clk) disable iff (!rst_n)
    ctrlOut.stackPop |-> (phaseOut == mnr_pkg::Q4 && !ctrlOut.gieSet);
  endproperty
  a_pop_q4: assert property (p_pop_q4)
    else $error("stack pop outside Q4");

  // Every cycle is four phases, so a move completes in one of them
  property p_cycle_wrap;
    @(posedge sys_clk) disable iff (!rst_n)
    (clkEn && lastPhase) |=> (phase == mnr_pkg::Q1);
  endproperty
  a_cycle_wrap: assert property (p_cycle_wrap)
    else $error("instruction cycle not four phases");

  c_move:   cover property (@(posedge sys_clk) ctrlOut.fileWrite);
  c_retint: cover property (@(posedge sys_clk) ctrlOut.stackPop);
  c_flush:  cover property (@(posedge sys_clk) ctrlOut.flush);
  c_nop:    cover property (@(posedge sys_clk)
    clkEn && phase == mnr_pkg::Q1 && isNop);
endmodule

/* File: testbench/test_move_nop_retint_decode.sv */
// Purpose: Self-checking bench for the move/no-op/return decoder
// Assumes: Inputs change on the falling edge, results settle by the next one
// Notes:   Expected strobes are queued by the driver, popped by a monitor
module test_move_nop_retint_decode;
  timeunit 1ns;
  timeprecision 1ps;
  // Kind, phase and payload of one expected or observed strobe
  typedef struct packed
  {
    logic [1:0]  kind;
    logic [1:0]  ph;
    logic [14:0] val;
  } mnr_note_s;
  logic                       sys_clk;
  logic                       rst_n;
  logic                       clkEn;
  logic [13:0]                instrWord;
  logic [7:0]                 workingReg;
  logic [12:0]                stackTopValue;
  logic [7:0]                 intCtrlIn;
  mnr_pkg::mnr_ctrl_s         ctrlOut;
  logic [7:0]                 intCtrlOut;
  mnr_pkg::mnr_phase_e        phaseOut;
  mnr_pkg::mnr_exec_e         execOut;
  logic                       statusWrite;
  mnr_note_s                  notes[$];
  mnr_note_s                  seen;
  logic                       seenValid;
  logic                       lastEn;
  logic                       stallOn;
  int                         miscompares;
  int                         n_checks;
  int                         nFlush;
  int                         nRet;
  // Words one bit away from return-from-interrupt
  localparam logic [13:0] NEAR_MISS [4] = '{14'h0008, 14'h0001,
                                            14'h0019, 14'h000B};

  mnr_decode mnr_decode_i
  (
    .sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
    .instrWord(instrWord), .workingReg(workingReg),
    .stackTopValue(stackTopValue), .intCtrlIn(intCtrlIn),
    .ctrlOut(ctrlOut), .intCtrlOut(intCtrlOut), .phaseOut(phaseOut),
    .execOut(execOut), .statusWrite(statusWrite)
  );

  // Free-running 25 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Counts enabled edges only, so random stalls never shift the phases
  task automatic step(input int n);
    while (n > 0)
    begin
      @(posedge sys_clk);
      if (clkEn === 1'b1)
        n--;
    end
  endtask

  // Word goes out before Q1; data changes only after Q1, since it is
  // still sampled on the edge that closes Q4
  task automatic issue(input logic [13:0] w);
    @(negedge sys_clk);
    instrWord = w;
    step(1);
    @(negedge sys_clk);
    workingReg    = 8'($urandom);
    stackTopValue = 13'($urandom);
    intCtrlIn     = 8'($urandom);
    if (w[13:7] == 7'h01)
    begin
      notes.push_back({2'd0, 2'd1, {8'h00, w[6:0]}});
      notes.push_back({2'd1, 2'd3, {w[6:0], workingReg}});
    end
    else if (w == 14'h0009)
    begin
      notes.push_back({2'd2, 2'd2, {7'h00, intCtrlIn | 8'h80}});
      notes.push_back({2'd3, 2'd3, {2'b00, stackTopValue}});
      nRet++;
      step(3);
      @(negedge sys_clk);
      instrWord = 14'h0080 | 14'($urandom_range(0, 127)); // Must be dropped
    end
    step(w == 14'h0009 ? 4 : 3);
  endtask

  // Random stalls once enabled; outputs hold while frozen
  always @(negedge sys_clk)
    clkEn <= stallOn ? ($urandom % 4 != 0) : 1'b1;
  always @(posedge sys_clk)
    lastEn <= clkEn & rst_n;

  // Monitor: each fresh strobe is matched against the oldest note
  always @(negedge sys_clk)
    if (lastEn === 1'b1)
    begin
      check(statusWrite, 1'b0);
      if (ctrlOut.flush === 1'b1)
      begin
        nFlush++;
        check(execOut, mnr_pkg::EX_FLUSH);
      end
      seenValid = 1'b1;
      if (ctrlOut.fileRead === 1'b1)
        seen = {2'd0, phaseOut, {8'h00, ctrlOut.fileAddr}};
      else if (ctrlOut.fileWrite === 1'b1)
        seen = {2'd1, phaseOut, {ctrlOut.fileAddr, ctrlOut.fileWData}};
      else if (ctrlOut.gieSet === 1'b1)
        seen = {2'd2, phaseOut, {7'h00, intCtrlOut}};
      else if (ctrlOut.pcLoad === 1'b1)
      begin
        seen = {2'd3, phaseOut, {2'b00, ctrlOut.pcValue}};
        check(ctrlOut.stackPop, 1'b1);
      end
      else
        seenValid = 1'b0;
      if (seenValid && notes.size() == 0)
        check(32'd0, 32'd1);
      else if (seenValid)
        check(seen, notes.pop_front());
    end

  // Watchdog well beyond the expected run length
  initial
  begin
    #800000;
    miscompares++;
    end_of_test();
  end

  initial
  begin
    void'($urandom(20776));
    {rst_n, stallOn, instrWord, workingReg} = '0;
    {stackTopValue, intCtrlIn, nFlush, nRet} = '0;
    {miscompares, n_checks} = '0;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    step(4);
    // Every don't-care variant of no-op, then near misses of return
    for (int i = 0; i < 4; i++)
      issue(14'(i) << 5);
    for (int j = 0; j < 4; j++)
      issue(NEAR_MISS[j]);
    // Random mix, back to back, stalls in the second half
    for (int k = 0; k < 48; k++)
    begin
      stallOn = (k >= 24);
      case ($urandom % 3)
        0: issue(14'h0080 | 14'($urandom_range(0, 127)));
        1: issue(14'h0009);
        default: issue(14'($urandom_range(0, 3)) << 5);
      endcase
    end
    issue(14'h0000);
    issue(14'h0000);
    check(32'(notes.size()), 32'd0);
    check(32'(nFlush), 32'(4 * nRet));
    end_of_test();
  end
endmodule
